// File: src/stregs_top.sv
// switch threshold register bank with strobed register port
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - reg 29h holds levels 1 high, 0 low
// - reg 2Ah holds levels 3 high, 2 low
// - reg 2Bh holds levels 5 high, 4 low
// - reg 2Ch holds levels 7 high, 6 low
// - reg 2Dh holds levels 9 high, 8 low
// - bits 23-20 read zero, fields read/write
// - all levels reset to zero
module stregs_top
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [23:0] reg_rdata,
  output logic      [9:0]  limit_level_0,
  output logic      [9:0]  limit_level_1,
  output logic      [9:0]  limit_level_2,
  output logic      [9:0]  limit_level_3,
  output logic      [9:0]  limit_level_4,
  output logic      [9:0]  limit_level_5,
  output logic      [9:0]  limit_level_6,
  output logic      [9:0]  limit_level_7,
  output logic      [9:0]  limit_level_8,
  output logic      [9:0]  limit_level_9
);
  // ****************************************
  // address decode
  // ****************************************
  function automatic logic [4:0] stregs_decode(input logic [7:0] a);
    stregs_decode = {a == stregs_pkg::OFS_PAIR_E, a == stregs_pkg::OFS_PAIR_D,
                     a == stregs_pkg::OFS_PAIR_C, a == stregs_pkg::OFS_PAIR_B,
                     a == stregs_pkg::OFS_PAIR_A};
  endfunction

  stregs_bus_if bus ();
  logic [4:0]  hit;
  logic [19:0] rd_sel;
  logic [23:0] next_rdata;

  assign hit         = stregs_decode(reg_addr);
  assign bus.wr_sel  = reg_wr ? hit : 5'h00;
  assign bus.wr_data = reg_wdata[19:0];

  stregs_store u_store
  (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .bus     (bus)
  );

  // ****************************************
  // read path
  // ****************************************
  assign rd_sel = hit[0] ? bus.rd_word[0] :
                  hit[1] ? bus.rd_word[1] :
                  hit[2] ? bus.rd_word[2] :
                  hit[3] ? bus.rd_word[3] :
                  hit[4] ? bus.rd_word[4] : 20'h00000;
  assign next_rdata = (|hit) ? {4'h0, rd_sel} : stregs_pkg::UNMAPPED_RD;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      reg_rdata <= 24'h000000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 24'h000000;
  end

  // ****************************************
  // field outputs
  // ****************************************
  assign limit_level_0 = bus.rd_word[0][9:0];
  assign limit_level_1 = bus.rd_word[0][19:10];
  assign limit_level_2 = bus.rd_word[1][9:0];
  assign limit_level_3 = bus.rd_word[1][19:10];
  assign limit_level_4 = bus.rd_word[2][9:0];
  assign limit_level_5 = bus.rd_word[2][19:10];
  assign limit_level_6 = bus.rd_word[3][9:0];
  assign limit_level_7 = bus.rd_word[3][19:10];
  assign limit_level_8 = bus.rd_word[4][9:0];
  assign limit_level_9 = bus.rd_word[4][19:10];

  // ****************************************
  // checks
  // ****************************************
  a_pair_a_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == stregs_pkg::OFS_PAIR_A
    |=> {limit_level_1, limit_level_0} == $past(reg_wdata[19:0]))
    else $error("pair a write lost");
  a_pair_b_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == stregs_pkg::OFS_PAIR_B
    |=> {limit_level_3, limit_level_2} == $past(reg_wdata[19:0]))
    else $error("pair b write lost");
  a_pair_c_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == stregs_pkg::OFS_PAIR_C
    |=> {limit_level_5, limit_level_4} == $past(reg_wdata[19:0]))
    else $error("pair c write lost");
  a_pair_d_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == stregs_pkg::OFS_PAIR_D
    |=> {limit_level_7, limit_level_6} == $past(reg_wdata[19:0]))
    else $error("pair d write lost");
  a_pair_e_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == stregs_pkg::OFS_PAIR_E
    |=> {limit_level_9, limit_level_8} == $past(reg_wdata[19:0]))
    else $error("pair e write lost");
  a_rsvd_read_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd |=> reg_rdata[23:20] == 4'h0)
    else $error("reserved bits read nonzero");
  a_reset_levels: assert property (@(posedge sys_clk)
    !nrst |=> limit_level_0 == 10'h000 && limit_level_9 == 10'h000)
    else $error("levels not cleared by reset");
  a_read_back: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == stregs_pkg::OFS_PAIR_A ##1 reg_rd && reg_addr == stregs_pkg::OFS_PAIR_A
    |=> reg_rdata == {4'h0, $past(reg_wdata[19:0], 2)})
    else $error("read back mismatch");
endmodule // stregs_top

// File: src/stregs_pkg.sv
// constants for the switch threshold register bank
package stregs_pkg;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 24;
  localparam int unsigned LEVEL_W      = 10;
  localparam int unsigned NUM_REGS     = 5;
  localparam int unsigned NUM_LEVELS   = 10;
  localparam logic [7:0]  OFS_PAIR_A   = 8'h29;
  localparam logic [7:0]  OFS_PAIR_B   = 8'h2A;
  localparam logic [7:0]  OFS_PAIR_C   = 8'h2B;
  localparam logic [7:0]  OFS_PAIR_D   = 8'h2C;
  localparam logic [7:0]  OFS_PAIR_E   = 8'h2D;
  localparam int unsigned LO_LSB       = 0;
  localparam int unsigned HI_LSB       = 10;
  localparam int unsigned RSVD_LSB     = 20;
  localparam logic [9:0]  LEVEL_RESET  = 10'h000;
  localparam logic [23:0] UNMAPPED_RD  = 24'h000000;
endpackage

// File: src/stregs_bus_if.sv
// register port carried between the bank and its field store
`timescale 1ns/1ps
interface stregs_bus_if;
  logic [stregs_pkg::NUM_REGS-1:0] wr_sel;
  logic [19:0]                     wr_data;
  logic [19:0]                     rd_word [stregs_pkg::NUM_REGS];
  modport bank  (output wr_sel, output wr_data, input rd_word);
  modport store (input wr_sel, input wr_data, output rd_word);
endinterface

// File: src/stregs_store.sv
// storage of the ten threshold fields, two per register
`timescale 1ns/1ps
module stregs_store
(
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  stregs_bus_if.store        bus
);
  genvar g;
  generate
    for (g = 0; g < stregs_pkg::NUM_REGS; g++)
    begin : g_pair
      logic [19:0] pair;
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
          pair <= {stregs_pkg::LEVEL_RESET, stregs_pkg::LEVEL_RESET};
        else if (bus.wr_sel[g])
          pair <= bus.wr_data;
      end
      assign bus.rd_word[g] = pair;
    end
  endgenerate
endmodule // stregs_store

// File: tb/stregs_tb.sv
// self-checking bench for the switch threshold register bank
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [23:0] reg_rdata;
  logic [23:0] got;
  logic [9:0]  lv [10];
  logic [9:0]  mdl [10];
  logic [31:0] seed = 32'h73CA;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  stregs_top DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .limit_level_0(lv[0]),
    .limit_level_1(lv[1]), .limit_level_2(lv[2]), .limit_level_3(lv[3]), .limit_level_4(lv[4]),
    .limit_level_5(lv[5]), .limit_level_6(lv[6]), .limit_level_7(lv[7]), .limit_level_8(lv[8]),
    .limit_level_9(lv[9]));
  initial forever #20 sys_clk = ~sys_clk;
  // ****************************************
  // bus tasks and reference model
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] expv(input logic [7:0] a);
    if (a < 8'h29 || a > 8'h2D)
      return 24'h000000;
    return {4'h0, mdl[2*(a-8'h29)+1], mdl[2*(a-8'h29)]};
  endfunction
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    if (a >= 8'h29 && a <= 8'h2D)
    begin
      mdl[2*(a-8'h29)]   = d[9:0];
      mdl[2*(a-8'h29)+1] = d[19:10];
    end
    #1;
  endtask
  task automatic sweep;
    for (int k = 0; k < 10; k++)
      check("level", 24'(lv[k]), 24'(mdl[k]));
    for (logic [7:0] a = 8'h28; a <= 8'h2E; a++)
    begin
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      got = reg_rdata;
      check("rdata", got, expv(a));
    end
  endtask
  task automatic wr_then_rd(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    if (a >= 8'h29 && a <= 8'h2D)
    begin
      mdl[2*(a-8'h29)]   = d[9:0];
      mdl[2*(a-8'h29)+1] = d[19:10];
    end
    @(posedge sys_clk);
    reg_rd    <= 1'b0;
    #1;
    got = reg_rdata;
    check("rdback", got, expv(a));
    @(posedge sys_clk);
    #1;
    got = reg_rdata;
    check("rdidle", got, 24'h000000);
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (mdl[k]) mdl[k] = 10'h000;
    sweep();
    $display("test reset done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    do_reset();
    for (int n = 0; n < 70; n++)
    begin
      seed = lfsr(seed);
      wr(8'h28 + 8'(n % 7), seed[23:0]);
      if (n % 7 == 6)
        sweep();
    end
    sweep();
    $display("test random writes done");
    for (int r = 0; r < 5; r++)
    begin
      seed = lfsr(seed);
      wr_then_rd(8'h29 + 8'(r), seed[23:0]);
    end
    sweep();
    $display("test back to back done");
    do_reset();
    give_verdict();
  end
endmodule // testbench
